//--- hw/low_power_mode_consts.vh
// constants for the low power mode controller
`ifndef LOW_POWER_MODE_CONSTS_VH
`define LOW_POWER_MODE_CONSTS_VH
// register indices, byte address is four times the index
`define POWER_CONTROL_IDX        8'h87
`define IDLE_PENDING_STATUS_IDX  8'h8e
`define STOP_PENDING_STATUS_IDX  8'h8f
`define POWER_CONTROL_RESET      8'h00
// power control field positions
`define PC_IDLE_BIT              0
`define PC_STOP_BIT              1
`define PC_TEST_MODE_BIT         2
`define PC_SOFT_RESET_BIT        5
`define PC_BAUD_DOUBLER_BIT      7
// low-speed clock select register (same map)
`define CLOCK_SELECT_IDX         8'h90
`define CLOCK_SELECT_RESET       8'h00
`define CS_SLOW_BIT              0
`define SRC_BITS                 7
// cycles the soft reset pulse stays asserted
`define SOFT_RESET_CYCLES        4'h4
`endif

//--- hw/low_power_mode_control.v
// power mode controller: idle, stop, low speed, soft reset
`timescale 1ns/1ps
// How it works
// - in idle the cpu is halted while the main clock keeps running.
// - idle is entered only when idle pending status reads all zero.
// - any reset or interrupt wakes idle; clock first, then interrupt.
// - after the wake service routine, execution continues after the idle request.
// - hardware clears the idle request bit on leaving idle.
// - stop halts all clocks; watchdog and rtc clocks continue if enabled.
// - stop is entered only when stop pending status reads all zero.
// - stop exits on any listed wake source: interrupts or resets.
// - on interrupt wake from stop, clock restores, interrupt serviced, then resume.
// - hardware clears the stop request bit on leaving stop.
// - on stop entry the system clock is gated after its final edge.
// - writing one to bit 5 gives a soft reset; bit self clears.
// - bit 2 reads one in test mode, zero otherwise.
// - bit 1 requests stop, bit 0 requests idle; both write only.
// - idle status reports pending interrupts per seven source groups.
// - stop status reports wake sources in the same groups; bit 7 reserved.
// - low-speed mode runs the main clock from the slow oscillator.
`include "low_power_mode_consts.vh"

module low_power_mode_control #(
  parameter SRC_W = `SRC_BITS
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire [SRC_W-1:0] idle_irq_pending,
  input  wire [SRC_W-1:0] stop_wake_pending,
  input  wire             wake_reset,
  input  wire             test_mode_pin,
  output wire             cpu_halt,
  output wire             main_clock_enable,
  output wire             clock_gen_enable,
  output wire             resume_clock,
  output wire             soft_reset_out,
  output wire             serial_baud_doubler,
  output wire             slow_clock_select
);

  // ****************************************************************
  // constants and states
  // ****************************************************************
  localparam [1:0] ST_RUN  = 2'b00;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_STOP = 2'b10;

  localparam [9:0] A_PC  = {`POWER_CONTROL_IDX, 2'b00};
  localparam [9:0] A_IPS = {`IDLE_PENDING_STATUS_IDX, 2'b00};
  localparam [9:0] A_SPS = {`STOP_PENDING_STATUS_IDX, 2'b00};
  localparam [9:0] A_CS  = {`CLOCK_SELECT_IDX, 2'b00};

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  reg [SRC_W-1:0] idle_s1_q;
  reg [SRC_W-1:0] idle_s2_q;
  reg [SRC_W-1:0] stop_s1_q;
  reg [SRC_W-1:0] stop_s2_q;
  reg             wrst_s1_q;
  reg             wrst_s2_q;
  reg             test_s1_q;
  reg             test_s2_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_s1_q <= {SRC_W{1'b0}};
      idle_s2_q <= {SRC_W{1'b0}};
      stop_s1_q <= {SRC_W{1'b0}};
      stop_s2_q <= {SRC_W{1'b0}};
      wrst_s1_q <= 1'b0;
      wrst_s2_q <= 1'b0;
      test_s1_q <= 1'b0;
      test_s2_q <= 1'b0;
    end else begin
      idle_s1_q <= idle_irq_pending;
      idle_s2_q <= idle_s1_q;
      stop_s1_q <= stop_wake_pending;
      stop_s2_q <= stop_s1_q;
      wrst_s1_q <= wake_reset;
      wrst_s2_q <= wrst_s1_q;
      test_s1_q <= test_mode_pin;
      test_s2_q <= test_s1_q;
    end
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************
  function is_addr;
    input [11:0] a;
    input [9:0]  r;
    begin
      is_addr = (a[11:10] == 2'b00) && (a[9:0] == r);
    end
  endfunction

  wire access   = psel & penable;
  wire hit_pc   = is_addr(paddr, A_PC);
  wire hit_ips  = is_addr(paddr, A_IPS);
  wire hit_sps  = is_addr(paddr, A_SPS);
  wire hit_cs   = is_addr(paddr, A_CS);
  wire mapped   = hit_pc | hit_ips | hit_sps | hit_cs;
  wire wr_pc    = access & pwrite & hit_pc;
  wire wr_cs    = access & pwrite & hit_cs;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // ****************************************************************
  // power control register and mode state machine
  // ****************************************************************
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg       idle_req_q;
  reg       stop_req_q;
  reg       baud_q;
  reg       slow_q;
  reg       resume_q;
  reg [3:0] srst_cnt_q;

  wire idle_clear = (idle_s2_q == {SRC_W{1'b0}});
  wire stop_clear = (stop_s2_q == {SRC_W{1'b0}});
  // any idle interrupt or any reset wakes idle
  wire idle_wake  = ~idle_clear | wrst_s2_q;
  // the stop source set already groups every listed wake source
  wire stop_wake  = ~stop_clear | wrst_s2_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (stop_req_q && stop_clear) begin
          state_d = ST_STOP;
        end else if (idle_req_q && idle_clear) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (idle_wake) begin
          state_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (stop_wake) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // a wake reset or soft reset returns the machine to run from any state
  wire       soft_rst   = (srst_cnt_q != 4'h0);
  wire       force_run  = wrst_s2_q | soft_rst;
  wire [1:0] state_next = force_run ? ST_RUN : state_d;
  wire       leave_idle = (state_q == ST_IDLE) && (state_next == ST_RUN);
  wire       leave_stop = (state_q == ST_STOP) && (state_next == ST_RUN);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_RUN;
      idle_req_q <= 1'b0;
      stop_req_q <= 1'b0;
      baud_q     <= 1'b0;
      slow_q     <= 1'b0;
      resume_q   <= 1'b0;
      srst_cnt_q <= 4'h0;
    end else begin
      state_q <= state_next;
      resume_q <= leave_idle | leave_stop;
      if (leave_idle || force_run) begin
        idle_req_q <= 1'b0;
      end else if (wr_pc && pwdata[`PC_IDLE_BIT]) begin
        idle_req_q <= 1'b1;
      end
      if (leave_stop || force_run) begin
        stop_req_q <= 1'b0;
      end else if (wr_pc && pwdata[`PC_STOP_BIT]) begin
        stop_req_q <= 1'b1;
      end
      if (wr_pc) begin
        baud_q <= pwdata[`PC_BAUD_DOUBLER_BIT];
      end
      if (wr_cs) begin
        slow_q <= pwdata[`CS_SLOW_BIT];
      end
      if (wr_pc && pwdata[`PC_SOFT_RESET_BIT]) begin
        srst_cnt_q <= `SOFT_RESET_CYCLES;
      end else if (srst_cnt_q != 4'h0) begin
        srst_cnt_q <= srst_cnt_q - 4'h1;
      end
    end
  end

  // ****************************************************************
  // clock and cpu control outputs
  // ****************************************************************
  assign cpu_halt            = (state_q != ST_RUN);
  assign main_clock_enable   = (state_q != ST_STOP);
  // the gate drops after the edge that loads the stop state
  assign clock_gen_enable    = (state_q != ST_STOP);
  assign resume_clock        = resume_q;
  assign soft_reset_out      = (srst_cnt_q != 4'h0);
  assign serial_baud_doubler = baud_q;
  assign slow_clock_select   = slow_q;

  // ****************************************************************
  // read data
  // ****************************************************************
  always @* begin
    prdata = 32'h0000_0000;
    if (hit_pc) begin
      prdata[`PC_BAUD_DOUBLER_BIT] = baud_q;
      prdata[`PC_TEST_MODE_BIT]    = test_s2_q;
    end else if (hit_ips) begin
      prdata[SRC_W-1:0] = idle_s2_q;
    end else if (hit_sps) begin
      prdata[SRC_W-1:0] = stop_s2_q;
    end else if (hit_cs) begin
      prdata[`CS_SLOW_BIT] = slow_q;
    end
  end

endmodule

//--- dv/irq_source_model.sv
// interrupt and wake source model on the far side of the power controller
`timescale 1ns/1ps
module irq_source_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic [6:0] idle_raise,
  input  logic [6:0] stop_raise,
  input  logic       drop,
  input  logic       resume_clock,
  output logic [6:0] idle_irq_pending,
  output logic [6:0] stop_wake_pending
);
  // a raised source stays pending until drop or a resume_clock pulse clears it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || drop || resume_clock) begin
      idle_irq_pending  <= 7'h00;
      stop_wake_pending <= 7'h00;
    end else begin
      idle_irq_pending  <= idle_irq_pending | idle_raise;
      stop_wake_pending <= stop_wake_pending | stop_raise;
    end
  end
endmodule

//--- dv/low_power_mode_chk.sv
// concurrent checks on the power mode controller ports
`timescale 1ns/1ps
module low_power_mode_chk #(
  parameter SRC_W = 7
) (
  input logic             pclk,
  input logic             presetn,
  input logic             psel,
  input logic             penable,
  input logic             pwrite,
  input logic [11:0]      paddr,
  input logic [31:0]      pwdata,
  input logic [SRC_W-1:0] idle_irq_pending,
  input logic [SRC_W-1:0] stop_wake_pending,
  input logic             wake_reset,
  input logic             cpu_halt,
  input logic             main_clock_enable,
  input logic             clock_gen_enable,
  input logic             resume_clock,
  input logic             soft_reset_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_stop_halts_cpu: assert property (!main_clock_enable |-> cpu_halt)
    else $error("main clock stopped while cpu runs");
  a_gen_follows_main: assert property (clock_gen_enable == main_clock_enable)
    else $error("clock generator enable differs from main clock enable");
  a_resume_on_exit: assert property ($fell(cpu_halt) |-> ##[0:1] resume_clock)
    else $error("no clock resume after leaving sleep");
  a_idle_entry_gate: assert property ($rose(cpu_halt) && main_clock_enable |-> $past(idle_irq_pending, 3) == 0)
    else $error("idle entered with pending interrupts");
  a_stop_entry_gate: assert property ($fell(main_clock_enable) |-> $past(stop_wake_pending, 3) == 0)
    else $error("stop entered with pending wake sources");
  a_idle_wake_up: assert property (cpu_halt && main_clock_enable && |idle_irq_pending |-> ##[1:4] !cpu_halt)
    else $error("idle not left on interrupt");
  a_stop_wake_up: assert property (!main_clock_enable && (|stop_wake_pending || wake_reset) |-> ##[1:4] main_clock_enable)
    else $error("stop not left on wake source");
  a_soft_reset_len: assert property ($rose(soft_reset_out) |-> soft_reset_out[*4] ##1 !soft_reset_out)
    else $error("soft reset pulse length wrong");
  a_gate_on_entry: assert property ($fell(clock_gen_enable) |-> $rose(cpu_halt))
    else $error("clock gate dropped outside the stop entry edge");
  a_resume_single: assert property (resume_clock |=> !resume_clock)
    else $error("resume pulse longer than one cycle");
endmodule

//--- dv/testbench.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wake_reset = 0, test_mode_pin = 0, drop = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [6:0]  idle_raise = 0, stop_raise = 0, idle_irq_pending, stop_wake_pending;
  logic pready, pslverr, er, cpu_halt, main_clock_enable, clock_gen_enable, resume_clock;
  logic soft_reset_out, serial_baud_doubler, slow_clock_select;
  int   fail_count = 0, samples_checked = 0;
  always #12.5 pclk = ~pclk;
  low_power_mode_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .idle_irq_pending, .stop_wake_pending, .wake_reset, .test_mode_pin, .cpu_halt, .main_clock_enable,
    .clock_gen_enable, .resume_clock, .soft_reset_out, .serial_baud_doubler, .slow_clock_select);
  irq_source_model u_src (.pclk, .presetn, .idle_raise, .stop_raise, .drop, .resume_clock, .idle_irq_pending,
    .stop_wake_pending);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_run;
    for (int i = 0; i < 12 && cpu_halt !== 1'b0; i++) @(posedge pclk);
  endtask
  task end_sim;
    $display("mismatches %0d of %0d checks", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    xfer(0, 12'h21c, 0); chk(rd, 32'h0);
    test_mode_pin <= 1;
    repeat (4) @(posedge pclk);
    xfer(0, 12'h21c, 0); chk(rd, 32'h4);
    test_mode_pin <= 0;
    idle_raise <= 7'h55;
    stop_raise <= 7'h2a;
    @(posedge pclk);
    idle_raise <= 0;
    stop_raise <= 0;
    repeat (3) @(posedge pclk);
    xfer(0, 12'h238, 0); chk(rd, 32'h55);
    xfer(0, 12'h23c, 0); chk(rd, 32'h2a);
    xfer(1, 12'h21c, 3);
    repeat (6) @(posedge pclk);
    chk(cpu_halt, 0);
    chk(main_clock_enable, 1);
    wake_reset <= 1;
    drop <= 1;
    repeat (4) @(posedge pclk);
    wake_reset <= 0;
    drop <= 0;
    repeat (4) @(posedge pclk);
    xfer(1, 12'h21c, 1);
    repeat (3) @(posedge pclk);
    chk(cpu_halt, 1);
    chk(main_clock_enable, 1);
    idle_raise <= 7'h08;
    @(posedge pclk);
    idle_raise <= 0;
    wait_run; chk(cpu_halt, 0);
    repeat (4) @(posedge pclk);
    chk(cpu_halt, 0);
    xfer(1, 12'h240, 1);
    @(posedge pclk);
    chk(slow_clock_select, 1);
    xfer(1, 12'h21c, 2);
    repeat (3) @(posedge pclk);
    chk(main_clock_enable, 0);
    chk(clock_gen_enable, 0);
    stop_raise <= 7'h01;
    @(posedge pclk);
    stop_raise <= 0;
    wait_run; chk(main_clock_enable, 1);
    repeat (4) @(posedge pclk);
    chk(cpu_halt, 0);
    xfer(1, 12'h21c, 2);
    repeat (3) @(posedge pclk);
    wake_reset <= 1;
    wait_run; chk(main_clock_enable, 1);
    wake_reset <= 0;
    xfer(1, 12'h21c, 32'h20);
    repeat (2) @(posedge pclk);
    chk(soft_reset_out, 1);
    xfer(1, 12'h240, 0);
    @(posedge pclk);
    chk(slow_clock_select, 0);
    xfer(1, 12'h21c, 32'h80);
    @(posedge pclk);
    chk(serial_baud_doubler, 1);
    xfer(0, 12'h21c, 0); chk(rd, 32'h80);
    xfer(0, 12'h400, 0); chk({er, rd[30:0]}, 32'h80000000);
    end_sim;
  end
  initial begin
    #100000;
    fail_count++;
    end_sim;
  end
endmodule
bind low_power_mode_control low_power_mode_chk #(.SRC_W(SRC_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .idle_irq_pending, .stop_wake_pending, .wake_reset, .cpu_halt, .main_clock_enable,
  .clock_gen_enable, .resume_clock, .soft_reset_out);
